// ===== rtl/mcrm_top.sv
// Clock scheme, loop detector, rate matching buffer and register slave.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module mcrm_top (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] awaddr,
	input  wire logic       awvalid,
	output logic            awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0] wstrb,
	input  wire logic       wvalid,
	output logic            wready,
	output logic      [1:0] bresp,
	output logic            bvalid,
	input  wire logic       bready,
	input  wire logic [7:0] araddr,
	input  wire logic       arvalid,
	output logic            arready,
	output logic     [31:0] rdata,
	output logic      [1:0] rresp,
	output logic            rvalid,
	input  wire logic       rready,
	input  wire logic [1:0] clock_scheme_select,
	input  wire logic       transport_in_clock,
	input  wire logic       input_valid,
	input  wire logic [7:0] input_byte,
	input  wire logic       sample_rate_clock,
	input  wire logic       nco_reference_clock,
	output logic            pump_up,
	output logic            pump_down,
	output logic            sample_strobe,
	output logic            symbol_strobe,
	output logic            io_strobe,
	output logic      [7:0] out_byte,
	output logic            out_valid,
	output logic            frame_start_out,
	output logic            irq
);
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == mcrm_pkg::CTRL_ADDR) || (a == mcrm_pkg::PRESC_ADDR) ||
			(a == mcrm_pkg::FDBK_ADDR) || (a == mcrm_pkg::STAT_ADDR) ||
			(a == mcrm_pkg::IRQ_ST_ADDR) || (a == mcrm_pkg::IRQ_MASK_ADDR) ||
			(a == mcrm_pkg::NCO_STEP_ADDR);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	mcrm_pkg::mcrm_ctrl_type     ctrl_reg;
	mcrm_pkg::mcrm_irq_type      irq_st_reg;
	mcrm_pkg::mcrm_irq_type      irq_mask_reg;
	mcrm_pkg::mcrm_irq_type      irq_set;
	mcrm_pkg::mcrm_rd_state_type rd_state_reg;
	logic [14:0] presc_reg;
	logic [14:0] fdbk_reg;
	logic [23:0] step_reg;
	logic [23:0] step_eff;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic        do_write;
	logic [31:0] wr_val;
	logic [31:0] wr_old;
	logic [1:0]  smp_gap_reg;
	logic        cap_done_reg;
	logic        scheme_nco_reg;
	logic        tin_prev_reg;
	logic        sr_prev_reg;
	logic        nr_prev_reg;
	logic        tin_rise;
	logic        sr_rise;
	logic        nr_rise;
	logic        nco_tick;
	logic        sample_tick;
	logic        symbol_tick;
	logic [1:0]  sym_cnt_reg;
	logic [14:0] presc_cnt_reg;
	logic [14:0] fdbk_cnt_reg;
	logic        ref_tick;
	logic        fb_tick;
	logic [7:0]  wr_ptr_reg;
	logic [7:0]  rd_ptr_reg;
	logic [7:0]  fill;
	logic        wr_en;
	logic        rd_en;
	logic        rd_pend_reg;
	logic [7:0]  rd_data;
	logic [7:0]  byte_cnt_reg;
	logic [4:0]  gap_cnt_reg;

	assign tin_rise = transport_in_clock & ~tin_prev_reg;
	assign sr_rise = sample_rate_clock & ~sr_prev_reg;
	assign nr_rise = nco_reference_clock & ~nr_prev_reg;
	assign fill = wr_ptr_reg - rd_ptr_reg;
	assign sample_tick = scheme_nco_reg ? nco_tick : sr_rise;
	assign symbol_tick = sample_tick && sym_cnt_reg == mcrm_pkg::SYM_DIV_LAST;
	assign ref_tick = tin_rise && presc_cnt_reg + 15'h0001 >= presc_reg;
	assign fb_tick = sr_rise && fdbk_cnt_reg + 15'h0001 >= fdbk_reg;
	assign wr_en = tin_rise && input_valid && ctrl_reg.enable &&
		fill != mcrm_pkg::BUF_DEPTH;
	assign rd_en = symbol_tick && rd_state_reg == mcrm_pkg::RD_RUN && fill != 8'h00;
	assign do_write = aw_held_reg && w_held_reg && !bvalid;
	assign wr_val = merge(wr_old, w_data_reg, w_strb_reg);

	// Status bits fall back to zero here, so their clear mask is the strobed bytes of the written word.
	always_comb begin
		unique case (aw_addr_reg)
			mcrm_pkg::CTRL_ADDR: wr_old = 32'(ctrl_reg);
			mcrm_pkg::PRESC_ADDR: wr_old = 32'(presc_reg);
			mcrm_pkg::FDBK_ADDR: wr_old = 32'(fdbk_reg);
			mcrm_pkg::IRQ_MASK_ADDR: wr_old = 32'(irq_mask_reg);
			mcrm_pkg::NCO_STEP_ADDR: wr_old = 32'(step_reg);
			default: wr_old = 32'h0;
		endcase
	end

	// The loop follows the buffer: a fuller buffer speeds the output side up.
	always_comb begin
		step_eff = step_reg;
		if (fill > mcrm_pkg::BUF_MID) begin
			step_eff = step_reg + (step_reg >> mcrm_pkg::NCO_TRIM_SHIFT);
		end else if (fill < mcrm_pkg::BUF_MID) begin
			step_eff = step_reg - (step_reg >> mcrm_pkg::NCO_TRIM_SHIFT);
		end
	end

	always_comb begin
		irq_set.overrun = tin_rise && input_valid && ctrl_reg.enable &&
			fill == mcrm_pkg::BUF_DEPTH;
		irq_set.underrun = symbol_tick && rd_state_reg == mcrm_pkg::RD_RUN && fill == 8'h00;
		irq_set.deviation = rd_state_reg != mcrm_pkg::RD_FILL &&
			(fill > mcrm_pkg::BUF_MID + mcrm_pkg::DEV_LIMIT ||
			fill < mcrm_pkg::BUF_MID - mcrm_pkg::DEV_LIMIT);
	end

	mcrm_nco u_nco (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ref_edge (nr_rise & scheme_nco_reg),
		.step     (step_eff),
		.tick     (nco_tick)
	);

	mcrm_buffer u_buf (
		.aclk    (aclk),
		.wr_en   (wr_en),
		.wr_addr (wr_ptr_reg[mcrm_pkg::BUF_AW-1:0]),
		.wr_data (input_byte),
		.rd_en   (rd_en),
		.rd_addr (rd_ptr_reg[mcrm_pkg::BUF_AW-1:0]),
		.rd_data (rd_data)
	);

	// The pins are caught once after reset; the board keeps them still afterwards.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_done_reg <= 1'b0;
			scheme_nco_reg <= 1'b0;
		end else if (!cap_done_reg) begin
			cap_done_reg <= 1'b1;
			scheme_nco_reg <= clock_scheme_select == mcrm_pkg::SCHEME_NCO;
		end
	end

	// The edge history follows the pins through reset, so a clock parked high gives no edge.
	always_ff @(posedge aclk) begin
		tin_prev_reg <= transport_in_clock;
		sr_prev_reg <= sample_rate_clock;
		nr_prev_reg <= nco_reference_clock;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_cnt_reg <= '0;
			fdbk_cnt_reg <= '0;
			pump_up <= 1'b0;
			pump_down <= 1'b0;
		end else if (scheme_nco_reg) begin
			pump_up <= 1'b0;
			pump_down <= 1'b0;
		end else begin
			presc_cnt_reg <= ref_tick ? 15'h0 : presc_cnt_reg + 15'(tin_rise);
			fdbk_cnt_reg <= fb_tick ? 15'h0 : fdbk_cnt_reg + 15'(sr_rise);
			if (ctrl_reg.freq_mode) begin
				pump_up <= ref_tick & ~fb_tick;
				pump_down <= fb_tick & ~ref_tick;
			end else if ((pump_up || ref_tick) && (pump_down || fb_tick)) begin
				pump_up <= 1'b0;
				pump_down <= 1'b0;
			end else begin
				pump_up <= pump_up | ref_tick;
				pump_down <= pump_down | fb_tick;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sym_cnt_reg <= '0;
			sample_strobe <= 1'b0;
			symbol_strobe <= 1'b0;
			io_strobe <= 1'b0;
		end else begin
			sym_cnt_reg <= sym_cnt_reg + 2'(sample_tick);
			sample_strobe <= sample_tick;
			symbol_strobe <= symbol_tick;
			io_strobe <= scheme_nco_reg ? nr_rise : sr_rise;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= '0;
		end else if (wr_en) begin
			wr_ptr_reg <= wr_ptr_reg + 8'h01;
		end
	end

	// Reads wait for half fill, then pause one parity length after every block.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= mcrm_pkg::RD_FILL;
			rd_ptr_reg <= '0;
			byte_cnt_reg <= '0;
			gap_cnt_reg <= '0;
			frame_start_out <= 1'b0;
		end else if (symbol_tick) begin
			unique case (rd_state_reg)
				mcrm_pkg::RD_FILL: begin
					if (fill >= mcrm_pkg::BUF_MID) begin
						rd_state_reg <= mcrm_pkg::RD_RUN;
					end
				end
				mcrm_pkg::RD_RUN: begin
					frame_start_out <= 1'b0;
					if (rd_en) begin
						rd_ptr_reg <= rd_ptr_reg + 8'h01;
						byte_cnt_reg <= byte_cnt_reg + 8'h01;
						if (byte_cnt_reg == mcrm_pkg::BLOCK_LEN - 8'h01) begin
							byte_cnt_reg <= '0;
							gap_cnt_reg <= mcrm_pkg::PARITY_LEN;
							frame_start_out <= 1'b1;
							rd_state_reg <= mcrm_pkg::RD_GAP;
						end
					end
				end
				mcrm_pkg::RD_GAP: begin
					gap_cnt_reg <= gap_cnt_reg - 5'h01;
					if (gap_cnt_reg == 5'h01) begin
						rd_state_reg <= mcrm_pkg::RD_RUN;
					end
				end
				default: rd_state_reg <= mcrm_pkg::RD_FILL;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend_reg <= 1'b0;
			out_valid <= 1'b0;
			out_byte <= '0;
		end else begin
			rd_pend_reg <= rd_en;
			out_valid <= rd_pend_reg;
			if (rd_pend_reg) begin
				out_byte <= rd_data;
			end
		end
	end

	// A new event wins over a clear written in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_reg <= '0;
			irq <= 1'b0;
		end else begin
			irq_st_reg <= irq_set | (irq_st_reg & ~((do_write && aw_addr_reg ==
				mcrm_pkg::IRQ_ST_ADDR) ? wr_val[2:0] : 3'h0));
			irq <= |(irq_st_reg & irq_mask_reg);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= mcrm_pkg::RESP_OKAY;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else begin
			awready <= !aw_held_reg && !(awvalid && awready) && !bvalid;
			wready <= !w_held_reg && !(wvalid && wready) && !bvalid;
			if (awvalid && awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid <= 1'b1;
				bresp <= addr_ok(aw_addr_reg) ? mcrm_pkg::RESP_OKAY : mcrm_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= mcrm_pkg::CTRL_RST;
			presc_reg <= mcrm_pkg::DIV_RST;
			fdbk_reg <= mcrm_pkg::DIV_RST;
			step_reg <= mcrm_pkg::NCO_STEP_RST;
			irq_mask_reg <= '0;
		end else if (do_write) begin
			unique case (aw_addr_reg)
				mcrm_pkg::CTRL_ADDR: ctrl_reg <= wr_val[1:0];
				mcrm_pkg::PRESC_ADDR: presc_reg <= wr_val[14:0];
				mcrm_pkg::FDBK_ADDR: fdbk_reg <= wr_val[14:0];
				mcrm_pkg::IRQ_MASK_ADDR: irq_mask_reg <= wr_val[2:0];
				mcrm_pkg::NCO_STEP_ADDR: step_reg <= wr_val[23:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= mcrm_pkg::RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= addr_ok(araddr) ? mcrm_pkg::RESP_OKAY : mcrm_pkg::RESP_SLVERR;
				unique case (araddr)
					mcrm_pkg::CTRL_ADDR: rdata <= 32'(ctrl_reg);
					mcrm_pkg::PRESC_ADDR: rdata <= 32'(presc_reg);
					mcrm_pkg::FDBK_ADDR: rdata <= 32'(fdbk_reg);
					mcrm_pkg::STAT_ADDR: rdata <= {21'h0, rd_state_reg, scheme_nco_reg, fill};
					mcrm_pkg::IRQ_ST_ADDR: rdata <= 32'(irq_st_reg);
					mcrm_pkg::IRQ_MASK_ADDR: rdata <= 32'(irq_mask_reg);
					mcrm_pkg::NCO_STEP_ADDR: rdata <= 32'(step_reg);
					default: rdata <= 32'h0;
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_WRITE_ONLY_VALID: assert property (
		wr_ptr_reg != $past(wr_ptr_reg) |-> $past(tin_rise && input_valid))
		else $error("Buffer written without a valid input edge.");
	AST_OVERRUN_FLAG: assert property (
		irq_set.overrun |=> irq_st_reg.overrun)
		else $error("Overrun not recorded.");
	AST_FILL_BOUND: assert property (
		fill <= mcrm_pkg::BUF_DEPTH)
		else $error("Buffer fill beyond depth.");
	AST_GAP_END: assert property (
		rd_state_reg == mcrm_pkg::RD_GAP && symbol_tick && gap_cnt_reg == 5'h01
		|=> rd_state_reg == mcrm_pkg::RD_RUN)
		else $error("Gap did not end after parity length.");
	// Sample strobes seen since the last symbol strobe, kept apart from the divider itself.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smp_gap_reg <= '0;
		end else if (sample_strobe) begin
			smp_gap_reg <= symbol_strobe ? 2'h0 : smp_gap_reg + 2'h1;
		end
	end

	AST_SYMBOL_DIV: assert property (
		sample_strobe || symbol_strobe |->
		sample_strobe && symbol_strobe == (smp_gap_reg == mcrm_pkg::SYM_DIV_LAST))
		else $error("Symbol strobe not on every fourth sample.");
	AST_SAMPLE_EXT: assert property (
		cap_done_reg && !scheme_nco_reg && sr_rise |=> sample_strobe)
		else $error("External sample edge not used.");
	AST_IO_TIMING: assert property (
		scheme_nco_reg && nr_rise |=> io_strobe)
		else $error("Output strobe not on reference edge.");
	AST_PHASE_UP: assert property (
		!scheme_nco_reg && !ctrl_reg.freq_mode && ref_tick && !fb_tick && !pump_down
		|=> pump_up)
		else $error("Phase detector missed a reference edge.");
	AST_SCHEME_HOLD: assert property (
		cap_done_reg && $past(cap_done_reg) |-> $stable(scheme_nco_reg))
		else $error("Clock scheme changed during operation.");
endmodule

// ===== rtl/mcrm_pkg.sv
// Constants, types and register map for the modulator clock and rate matching block.
package mcrm_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] PRESC_ADDR = 8'h04;
	localparam logic [7:0] FDBK_ADDR = 8'h08;
	localparam logic [7:0] STAT_ADDR = 8'h0c;
	localparam logic [7:0] IRQ_ST_ADDR = 8'h10;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;
	localparam logic [7:0] NCO_STEP_ADDR = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SCHEME_NCO = 2'h2;
	localparam int BUF_AW = 7;
	localparam logic [7:0] BUF_DEPTH = 8'h80;
	localparam logic [7:0] BUF_MID = 8'h40;
	localparam logic [7:0] DEV_LIMIT = 8'h38;
	localparam logic [4:0] PARITY_LEN = 5'h10;
	localparam logic [7:0] BLOCK_LEN = 8'hbc;
	localparam logic [1:0] SYM_DIV_LAST = 2'h3;
	localparam int NCO_W = 24;
	localparam logic [23:0] NCO_STEP_RST = 24'h400000;
	localparam int NCO_TRIM_SHIFT = 6;
	localparam logic [14:0] DIV_RST = 15'h0001;
	localparam int CTRL_FREQ_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam int STAT_SCHEME_BIT = 8;
	localparam int IRQ_OVR_BIT = 0;
	localparam int IRQ_UNR_BIT = 1;
	localparam int IRQ_DEV_BIT = 2;

	typedef struct packed {
		logic enable;
		logic freq_mode;
	} mcrm_ctrl_type;

	typedef struct packed {
		logic deviation;
		logic underrun;
		logic overrun;
	} mcrm_irq_type;

	typedef enum logic [1:0] {
		RD_FILL = 2'h0,
		RD_RUN  = 2'h1,
		RD_GAP  = 2'h3
	} mcrm_rd_state_type;
endpackage

// ===== rtl/mcrm_buffer.sv
// Circular input buffer storage with registered read data.
`timescale 1ns/1ps
module mcrm_buffer (
	input  wire logic                       aclk,
	input  wire logic                       wr_en,
	input  wire logic [mcrm_pkg::BUF_AW-1:0] wr_addr,
	input  wire logic [7:0]                 wr_data,
	input  wire logic                       rd_en,
	input  wire logic [mcrm_pkg::BUF_AW-1:0] rd_addr,
	output logic      [7:0]                 rd_data
);
	logic [7:0] mem [0:(1<<mcrm_pkg::BUF_AW)-1];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// ===== rtl/mcrm_nco.sv
// Phase accumulator that turns reference clock edges into sample ticks.
`timescale 1ns/1ps
module mcrm_nco (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      ref_edge,
	input  wire logic [mcrm_pkg::NCO_W-1:0] step,
	output logic                           tick
);
	logic [mcrm_pkg::NCO_W-1:0] phase_reg;
	logic [mcrm_pkg::NCO_W:0]   sum;

	assign sum = {1'b0, phase_reg} + {1'b0, step};

	// A carry out of the accumulator is one sample period.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= '0;
			tick <= 1'b0;
		end else begin
			tick <= ref_edge & sum[mcrm_pkg::NCO_W];
			if (ref_edge) begin
				phase_reg <= sum[mcrm_pkg::NCO_W-1:0];
			end
		end
	end
endmodule

// ===== verification/mcrm_source.sv
// Transport source model giving a byte clock, a valid flag and data bytes.
`timescale 1ns/1ps
module mcrm_source (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic       valid_en,
	input  wire logic [7:0] half,
	output logic            transport_in_clock,
	output logic            input_valid,
	output logic      [7:0] input_byte,
	output logic      [7:0] sent
);
	logic [7:0] cnt_reg;
	// The byte clock stands still while run is low, as it does between frames.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg            <= 8'h00;
			transport_in_clock <= 1'b0;
			input_valid        <= 1'b0;
			input_byte         <= 8'h00;
			sent               <= 8'h00;
		end else if (run) begin
			cnt_reg <= (cnt_reg == half - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
			if (cnt_reg == half - 8'h01) begin
				transport_in_clock <= !transport_in_clock;
				if (!transport_in_clock) begin
					// Invalid slots carry inverted data so a stale byte never looks good.
					input_valid <= valid_en;
					input_byte  <= valid_en ? sent : ~input_byte;
					sent        <= sent + {7'h00, valid_en};
				end
			end
		end
	end
endmodule

// ===== verification/test_mcrm_top.sv
// Self-checking bench for the clock control and rate matching block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module test_mcrm_top;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, input_valid, transport_in_clock;
	logic        sample_rate_clock, nco_reference_clock, pump_up, pump_down, irq;
	logic        sample_strobe, symbol_strobe, io_strobe, out_valid, frame_start_out;
	logic [7:0]  awaddr, araddr, input_byte, out_byte, half, sent, exp_b;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, strb;
	logic [1:0]  bresp, rresp, clock_scheme_select;
	logic        run, valid_en, src_run, ref_run, clr_req, pu_prev;
	int          miscompares, n_tests, cyc, src_rises, ref_rises;
	int          n_smp, n_sym, n_io, pu, pd, pu2, n_out, fs_len, fs_last;

	mcrm_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .clock_scheme_select, .transport_in_clock, .input_valid,
		.input_byte, .sample_rate_clock, .nco_reference_clock, .pump_up, .pump_down,
		.sample_strobe, .symbol_strobe, .io_strobe, .out_byte, .out_valid,
		.frame_start_out, .irq);
	mcrm_source src (.aclk, .aresetn, .run, .valid_en, .half, .transport_in_clock,
		.input_valid, .input_byte, .sent);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = !aclk;
	end

	// Oscillator every 8 cycles; reference every 4 cycles, twice the nominal rate.
	always @(posedge aclk) begin
		cyc++;
		if (!aresetn || clr_req) {src_rises, ref_rises} = '0;
		if (src_run && cyc % 4 == 0) sample_rate_clock <= !sample_rate_clock;
		if (src_run && cyc % 4 == 0 && !sample_rate_clock) src_rises++;
		if (ref_run && cyc % 2 == 0) nco_reference_clock <= !nco_reference_clock;
		if (ref_run && cyc % 2 == 0 && !nco_reference_clock) ref_rises++;
	end

	always @(posedge aclk) begin
		if (!aresetn || clr_req) begin
			{n_smp, n_sym, n_io, pu, pd, pu2, n_out, fs_len, fs_last} = '0;
			exp_b = 8'h00;
			pu_prev = 1'b0;
		end else begin
			n_smp += sample_strobe;
			n_sym += symbol_strobe;
			n_io += io_strobe;
			pu += pump_up;
			pd += pump_down;
			if (pump_up && pu_prev) pu2++;
			pu_prev = pump_up;
			if (out_valid) begin
				`CHK("out_byte", exp_b, out_byte)
				exp_b++;
				n_out++;
			end
			if (frame_start_out) fs_len++;
			else if (fs_len > 0) begin
				fs_last = fs_len;
				fs_len = 0;
			end
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		$display("FAIL timeout exp 0 got 1");
		miscompares++;
		stop_test();
	end

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// The scheme pins change only while reset is held.
	task automatic rst(input logic [1:0] s);
		aresetn <= 1'b0;
		clock_scheme_select <= s;
		run <= 1'b0;
		wt(10);
		aresetn <= 1'b1;
		wt(2);
	endtask

	task automatic clr();
		clr_req <= 1'b1;
		@(posedge aclk);
		clr_req <= 1'b0;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic cr(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		`CHK("reg_read", e, d)
	endtask

	task automatic t_regs();
		logic [7:0]  ra [7];
		logic [31:0] rv [7];
		logic [31:0] d;
		logic [1:0]  r;
		ra = '{mcrm_pkg::CTRL_ADDR, mcrm_pkg::PRESC_ADDR, mcrm_pkg::FDBK_ADDR,
			mcrm_pkg::STAT_ADDR, mcrm_pkg::IRQ_ST_ADDR, mcrm_pkg::IRQ_MASK_ADDR,
			mcrm_pkg::NCO_STEP_ADDR};
		rv = '{32'h2, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h400000};
		for (int i = 0; i < 7; i++) cr(ra[i], rv[i]);
		axr(8'h1c, d, r);
		`CHK("bad_rresp", mcrm_pkg::RESP_SLVERR, r)
		`CHK("bad_rdata", 32'h0, d)
		axw(8'h1c, 32'hffffffff, r);
		`CHK("bad_bresp", mcrm_pkg::RESP_SLVERR, r)
		axw(mcrm_pkg::STAT_ADDR, 32'hffffffff, r);
		cr(mcrm_pkg::STAT_ADDR, 32'h0);
		axw(mcrm_pkg::PRESC_ADDR, 32'hffffffff, r);
		cr(mcrm_pkg::PRESC_ADDR, 32'h7fff);
		axw(mcrm_pkg::FDBK_ADDR, 32'h12345, r);
		cr(mcrm_pkg::FDBK_ADDR, 32'h2345);
		strb = 4'h1;
		axw(mcrm_pkg::NCO_STEP_ADDR, 32'hffffffff, r);
		strb = 4'hf;
		cr(mcrm_pkg::NCO_STEP_ADDR, 32'h4000ff);
	endtask

	task automatic t_input();
		logic [1:0] r;
		logic [7:0] tgt;
		axw(mcrm_pkg::CTRL_ADDR, 32'h0, r);
		valid_en <= 1'b1;
		run <= 1'b1;
		wt(40);
		cr(mcrm_pkg::STAT_ADDR, 32'h0);
		// Invalid slots must flow before enable rises, or a late valid byte lands.
		valid_en <= 1'b0;
		wt(8);
		axw(mcrm_pkg::CTRL_ADDR, 32'h2, r);
		wt(40);
		cr(mcrm_pkg::STAT_ADDR, 32'h0);
		valid_en <= 1'b1;
		tgt = sent + 8'd100;
		while (sent !== tgt) @(posedge aclk);
		run <= 1'b0;
		wt(4);
		cr(mcrm_pkg::STAT_ADDR, 32'd100);
		run <= 1'b1;
		wt(200);
		run <= 1'b0;
		wt(4);
		cr(mcrm_pkg::STAT_ADDR, 32'h80);
		cr(mcrm_pkg::IRQ_ST_ADDR, 32'h1);
		`CHK("irq_masked", 1'b0, irq)
		axw(mcrm_pkg::IRQ_MASK_ADDR, 32'h7, r);
		wt(2);
		`CHK("irq_on", 1'b1, irq)
		axw(mcrm_pkg::IRQ_ST_ADDR, 32'h1, r);
		wt(2);
		`CHK("irq_off", 1'b0, irq)
		cr(mcrm_pkg::IRQ_ST_ADDR, 32'h0);
	endtask

	task automatic t_pump();
		logic [1:0] r;
		axw(mcrm_pkg::PRESC_ADDR, 32'h1, r);
		axw(mcrm_pkg::FDBK_ADDR, 32'h1, r);
		axw(mcrm_pkg::CTRL_ADDR, 32'h3, r);
		clr();
		run <= 1'b1;
		wt(200);
		run <= 1'b0;
		`CHK("freq_up", 1'b1, pu > 0)
		`CHK("freq_pulse", 0, pu2)
		`CHK("freq_down", 0, pd)
		axw(mcrm_pkg::CTRL_ADDR, 32'h2, r);
		clr();
		run <= 1'b1;
		wt(200);
		run <= 1'b0;
		`CHK("phase_level", 1'b1, pu2 > 0)
	endtask

	task automatic t_stream();
		rst(2'h0);
		half <= 8'd16;
		valid_en <= 1'b1;
		run <= 1'b1;
		src_run <= 1'b1;
		while (n_out < 200 || fs_last == 0) @(posedge aclk);
		`CHK("gap_len", 1'b1, fs_last inside {[16 * 32 : 18 * 32]})
		run <= 1'b0;
		wt(5000);
		src_run <= 1'b0;
		wt(20);
		// Draining while reads run leaves underrun and low fill, never overrun.
		cr(mcrm_pkg::IRQ_ST_ADDR, 32'h6);
		`CHK("sym_ratio", 1'b1, (n_smp - 4 * n_sym) inside {[-4 : 4]})
		`CHK("io_osc", src_rises, n_io)
		`CHK("smp_osc", src_rises, n_smp)
		`CHK("phase_down", 1'b1, pd > 0)
	endtask

	task automatic t_nco();
		rst(mcrm_pkg::SCHEME_NCO);
		cr(mcrm_pkg::STAT_ADDR, 32'h100);
		ref_run <= 1'b1;
		wt(1600);
		ref_run <= 1'b0;
		wt(20);
		`CHK("io_ref", ref_rises, n_io)
		`CHK("nco_pumps", 0, pu + pd)
		`CHK("nco_rate", 1'b1, n_smp inside {[90 : 101]})
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, run, valid_en} = '0;
		{src_run, ref_run, clr_req, sample_rate_clock, nco_reference_clock} = '0;
		{awaddr, araddr, wdata, wstrb, clock_scheme_select} = '0;
		half = 8'd2;
		strb = 4'hf;
		rst(2'h0);
		t_regs();
		t_input();
		t_pump();
		t_stream();
		t_nco();
		stop_test();
	end
endmodule
